// ### src/nmwd_decode.sv
// APB register block and claim logic of the memory window decoder.
`timescale 1ns/1ps
module nmwd_decode (
	// Clock, reset and clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nmwd_pkg::NMWD_PADDR_W-1:0] paddr,
	input wire logic [nmwd_pkg::NMWD_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [nmwd_pkg::NMWD_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host access request, same clock domain
	input wire logic host_valid,
	input wire logic host_mem,
	input wire logic [nmwd_pkg::NMWD_HADDR_W-1:0] host_addr,
	// Routing decision toward the secondary hub interface
	output logic fwd_valid,
	output logic fwd_claim
);
	import nmwd_pkg::*;

	nmwd_apb_state_type state_reg;
	nmwd_apb_state_type state_next;
	logic [NMWD_FIELD_W-1:0] base_reg;
	logic [NMWD_FIELD_W-1:0] base_next;
	logic [NMWD_FIELD_W-1:0] limit_reg;
	logic [NMWD_FIELD_W-1:0] limit_next;
	logic [NMWD_DATA_W-1:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic fwd_valid_reg;
	logic fwd_claim_reg;
	logic last_claim_reg;
	logic [15:0] claim_cnt_reg;
	logic [15:0] claim_cnt_next;

	nmwd_win_if win ();

	// Window compare lives in its own module so bounds logic stays in one place
	nmwd_window_cmp u_cmp (
		.win(win)
	);

	assign win.base_field = base_reg;
	assign win.limit_field = limit_reg;
	assign win.addr = host_addr;

	// Address decode and bus phases
	wire setup_phase;
	wire wr_commit;
	wire sel_base;
	wire sel_limit;
	wire sel_status;
	wire mapped;
	assign setup_phase = psel && !penable;
	assign wr_commit = psel && penable && pready_reg && pwrite;
	assign sel_base = (paddr == NMWD_BASE_ADDR);
	assign sel_limit = (paddr == NMWD_LIMIT_ADDR);
	assign sel_status = (paddr == NMWD_STATUS_ADDR);
	assign mapped = sel_base || sel_limit || sel_status;

	// Byte lanes: lane 0 carries field bits 3:0, lane 1 carries bits 11:4
	wire [NMWD_FIELD_W-1:0] wr_field;
	wire [NMWD_FIELD_W-1:0] lane_mask;
	assign wr_field = pwdata[NMWD_FIELD_MSB:NMWD_FIELD_LSB];
	assign lane_mask = {{8{pstrb[1]}}, {4{pstrb[0]}}};

	// Next field values; bits 3:0 have no storage at all
	assign base_next = (wr_commit && sel_base) ?
		((base_reg & ~lane_mask) | (wr_field & lane_mask)) : base_reg;
	assign limit_next = (wr_commit && sel_limit) ?
		((limit_reg & ~lane_mask) | (wr_field & lane_mask)) : limit_reg;

	// Readable views, reserved nibble forced to zero
	wire [15:0] base_view;
	wire [15:0] limit_view;
	wire [NMWD_DATA_W-1:0] status_view;
	wire [NMWD_DATA_W-1:0] rd_mux;
	assign base_view = {base_reg, NMWD_RSVD_VALUE};
	assign limit_view = {limit_reg, NMWD_RSVD_VALUE};
	assign status_view = {claim_cnt_reg, 14'h0000, last_claim_reg, win.open};
	assign rd_mux = sel_base ? {16'h0000, base_view} :
		sel_limit ? {16'h0000, limit_view} :
		sel_status ? status_view : 32'h00000000;

	// Claim only memory accesses inside the window; all else is left to others
	wire claim_now;
	assign claim_now = host_valid && host_mem && win.hit;
	assign claim_cnt_next = claim_now ? (claim_cnt_reg + 16'h0001) : claim_cnt_reg;

	// APB state: one wait-free access phase per transfer
	always_comb begin
		case (state_reg)
			NMWD_IDLE: state_next = setup_phase ? NMWD_ACK : NMWD_IDLE;
			NMWD_ACK: state_next = NMWD_IDLE;
			default: state_next = NMWD_IDLE;
		endcase
	end

	// Bus state and answer; read data captured in setup so pready and data agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= NMWD_IDLE;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			state_reg <= state_next;
			pready_reg <= (state_next == NMWD_ACK);
			pslverr_reg <= setup_phase && !mapped;
			prdata_reg <= (setup_phase && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Window registers; empty window after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_reg <= NMWD_BASE_RESET[NMWD_FIELD_MSB:NMWD_FIELD_LSB];
			limit_reg <= NMWD_LIMIT_RESET[NMWD_FIELD_MSB:NMWD_FIELD_LSB];
		end else if (ce) begin
			base_reg <= base_next;
			limit_reg <= limit_next;
		end
	end

	// Registered routing decision; one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_valid_reg <= 1'b0;
			fwd_claim_reg <= 1'b0;
			last_claim_reg <= 1'b0;
			claim_cnt_reg <= NMWD_CNT_RESET;
		end else if (ce) begin
			fwd_valid_reg <= host_valid;
			fwd_claim_reg <= claim_now;
			if (host_valid) begin
				last_claim_reg <= claim_now;
			end
			claim_cnt_reg <= claim_cnt_next;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign fwd_valid = fwd_valid_reg;
	assign fwd_claim = fwd_claim_reg;

	// Checks; ce is part of each host, write and setup trigger since a frozen block holds its outputs
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_claim_inside;
		ce && host_valid && host_mem && (host_addr >= {base_reg, NMWD_LOW_FILL})
			&& (host_addr <= {limit_reg, NMWD_HIGH_FILL}) |=> fwd_claim && fwd_valid;
	endproperty
	a_claim_inside: assert property (p_claim_inside)
		else $error("in-window memory access was not claimed");

	property p_write_field;
		ce && wr_commit && (sel_base || sel_limit) && (pstrb[1:0] == 2'b11) |=>
			($past(sel_base, 1) ? base_reg : limit_reg) == $past(pwdata[15:4], 1);
	endproperty
	a_write_field: assert property (p_write_field)
		else $error("window field did not take written bits 15:4");

	property p_reserved_zero;
		pready && psel && penable && !pwrite && !pslverr
			&& (sel_base || sel_limit) |-> prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved window register bits read nonzero");

	property p_base_aligned;
		ce && host_valid && host_mem && win.open
			&& (host_addr == {base_reg, NMWD_LOW_FILL}) |=> fwd_claim;
	endproperty
	a_base_aligned: assert property (p_base_aligned)
		else $error("window bottom on 1 MB boundary not claimed");

	property p_below_base;
		ce && host_valid && host_mem && (base_reg != 12'h000)
			&& (host_addr == {base_reg, NMWD_LOW_FILL} - 32'h00000001) |=> !fwd_claim;
	endproperty
	a_below_base: assert property (p_below_base)
		else $error("address just below window bottom was claimed");

	property p_limit_top;
		ce && host_valid && host_mem && win.open
			&& (host_addr == {limit_reg, NMWD_HIGH_FILL}) ##1 ce |-> fwd_claim;
	endproperty
	a_limit_top: assert property (p_limit_top)
		else $error("last byte of window top block not claimed");

	property p_base_reset;
		$rose(presetn) |-> {base_reg, NMWD_RSVD_VALUE} == NMWD_BASE_RESET;
	endproperty
	a_base_reset: assert property (p_base_reset)
		else $error("base register wrong after reset");

	property p_limit_reset;
		$rose(presetn) |-> limit_reg == 12'h000 && !win.open && !fwd_claim;
	endproperty
	a_limit_reset: assert property (p_limit_reset)
		else $error("limit register wrong or window open after reset");

	property p_outside_free;
		ce && host_valid && !(host_mem && win.hit) |=> !fwd_claim;
	endproperty
	a_outside_free: assert property (p_outside_free)
		else $error("access outside window was claimed");

	property p_answer_next;
		ce && setup_phase ##1 ce |-> pready && (pslverr == !$past(mapped, 1));
	endproperty
	a_answer_next: assert property (p_answer_next)
		else $error("APB answer missing one cycle after setup");

	// Main scenarios
	c_claim: cover property (ce && host_valid && host_mem ##1 fwd_claim);
	c_base_write: cover property (wr_commit && sel_base ##1 win.open);
	c_unmapped: cover property (pready && pslverr);
	c_read_limit: cover property (pready && !pwrite && sel_limit);

endmodule : nmwd_decode

// ### src/nmwd_pkg.sv
// Constants and types for the non-prefetchable memory window decoder.
package nmwd_pkg;

	// Bus and field widths
	localparam int unsigned NMWD_DATA_W = 32;
	localparam int unsigned NMWD_PADDR_W = 12;
	localparam int unsigned NMWD_HADDR_W = 32;
	localparam int unsigned NMWD_FIELD_W = 12;
	localparam int unsigned NMWD_FILL_W = 20;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] NMWD_BASE_IDX = 8'h20;
	localparam logic [7:0] NMWD_LIMIT_IDX = 8'h22;
	localparam logic [7:0] NMWD_STATUS_IDX = 8'h30;
	localparam logic [11:0] NMWD_BASE_ADDR = {2'h0, NMWD_BASE_IDX, 2'h0};
	localparam logic [11:0] NMWD_LIMIT_ADDR = {2'h0, NMWD_LIMIT_IDX, 2'h0};
	localparam logic [11:0] NMWD_STATUS_ADDR = {2'h0, NMWD_STATUS_IDX, 2'h0};

	// Window field position inside the 16-bit registers
	localparam int unsigned NMWD_FIELD_LSB = 4;
	localparam int unsigned NMWD_FIELD_MSB = 15;
	localparam logic [3:0] NMWD_RSVD_VALUE = 4'h0;

	// Values after reset
	localparam logic [15:0] NMWD_BASE_RESET = 16'hFFF0;
	localparam logic [15:0] NMWD_LIMIT_RESET = 16'h0000;
	localparam logic [15:0] NMWD_CNT_RESET = 16'h0000;

	// Fill of address bits 19:0 for the two compares
	localparam logic [19:0] NMWD_LOW_FILL = 20'h00000;
	localparam logic [19:0] NMWD_HIGH_FILL = 20'hFFFFF;

	// Status register layout
	localparam int unsigned NMWD_STAT_OPEN_BIT = 0;
	localparam int unsigned NMWD_STAT_LAST_BIT = 1;
	localparam int unsigned NMWD_STAT_CNT_LSB = 16;

	// APB slave states, Gray coded
	typedef enum logic [1:0] {
		NMWD_IDLE = 2'b00,
		NMWD_ACK = 2'b01
	} nmwd_apb_state_type;

endpackage : nmwd_pkg

// ### src/nmwd_win_if.sv
// Window compare signals between the register block and the comparator.
`timescale 1ns/1ps
interface nmwd_win_if;
	import nmwd_pkg::*;

	logic [NMWD_FIELD_W-1:0] base_field;
	logic [NMWD_FIELD_W-1:0] limit_field;
	logic [NMWD_HADDR_W-1:0] addr;
	logic hit;
	logic open;

	// Register side drives bounds and address
	modport ctrl (output base_field, output limit_field, output addr, input hit, input open);
	// Comparator side answers
	modport cmp (input base_field, input limit_field, input addr, output hit, output open);

endinterface : nmwd_win_if

// ### src/nmwd_window_cmp.sv
// Inclusive 1 MB granular window compare.
`timescale 1ns/1ps
module nmwd_window_cmp (
	// Window bounds and address under test
	nmwd_win_if.cmp win
);
	import nmwd_pkg::*;

	wire [NMWD_HADDR_W-1:0] low_bound;
	wire [NMWD_HADDR_W-1:0] high_bound;

	// Bounds widened to full addresses
	assign low_bound = {win.base_field, NMWD_LOW_FILL};
	assign high_bound = {win.limit_field, NMWD_HIGH_FILL};

	// Both ends inclusive; an inverted window matches nothing
	assign win.hit = (win.addr >= low_bound) && (win.addr <= high_bound);
	assign win.open = (win.base_field <= win.limit_field);

endmodule : nmwd_window_cmp

// ### testbench/nmwd_host_model.sv
// Host bus model presenting one request per go pulse, memory or not as req_mem sets.
`timescale 1ns/1ps
module nmwd_host_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request from the bench
	input wire logic go,
	input wire logic req_mem,
	input wire logic [31:0] req_addr,
	// Host bus toward the decoder
	output logic host_valid,
	output logic host_mem,
	output logic [31:0] host_addr
);
	// Idle bus inverts address and type each cycle, so the last request shows again every second idle cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_valid <= 1'b0;
			host_mem <= 1'b0;
			host_addr <= 32'h00000000;
		end else if (go) begin
			host_valid <= 1'b1;
			host_mem <= req_mem;
			host_addr <= req_addr;
		end else begin
			host_valid <= 1'b0;
			host_mem <= ~host_mem;
			host_addr <= ~host_addr;
		end
	end
endmodule : nmwd_host_model

// ### testbench/test_nonprefetch_memory_window_decode.sv
// Register and claim tests for the memory window decoder.
`timescale 1ns/1ps
module test_nonprefetch_memory_window_decode;
	import nmwd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic ce = 1'b1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic go = 1'b0;
	logic req_mem = 1'b0;
	logic [31:0] req_addr = 32'h00000000;
	logic host_valid;
	logic host_mem;
	logic [31:0] host_addr;
	logic fwd_valid;
	logic fwd_claim;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	// 50 MHz clock
	always #10 pclk = ~pclk;

	nmwd_decode dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .host_valid(host_valid),
		.host_mem(host_mem), .host_addr(host_addr), .fwd_valid(fwd_valid), .fwd_claim(fwd_claim));
	nmwd_host_model host_u (.pclk(pclk), .presetn(presetn), .go(go), .req_mem(req_mem),
		.req_addr(req_addr), .host_valid(host_valid), .host_mem(host_mem), .host_addr(host_addr));

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends when pready is seen high; if it never comes, only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One host access, decision looked at one cycle after it is sampled
	task automatic host(input logic m, input logic [31:0] a, input logic exp);
		@(posedge pclk);
		go <= 1'b1;
		req_mem <= m;
		req_addr <= a;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1;
		chk({31'h0, fwd_valid}, 32'h00000001);
		chk({31'h0, fwd_claim}, {31'h0, exp});
	endtask : host

	// Cut a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, NMWD_BASE_ADDR, 32'h0);
		chk(rd, 32'h0000FFF0);
		apb(1'b0, NMWD_LIMIT_ADDR, 32'h0);
		chk(rd, 32'h00000000);
		host(1'b1, 32'hFFF00000, 1'b0);
		host(1'b1, 32'h00000000, 1'b0);
		$display("reset values done");
		// Reserved low nibble dropped, upper field kept
		apb(1'b1, NMWD_BASE_ADDR, 32'h0000ABCF);
		apb(1'b0, NMWD_BASE_ADDR, 32'h0);
		chk(rd, 32'h0000ABC0);
		apb(1'b1, NMWD_LIMIT_ADDR, 32'h0000541F);
		apb(1'b0, NMWD_LIMIT_ADDR, 32'h0);
		chk(rd, 32'h00005410);
		host(1'b1, 32'h54000000, 1'b0);
		$display("register access done");
		// Both bounds set before any claim is trusted
		apb(1'b1, NMWD_BASE_ADDR, 32'h00001230);
		apb(1'b1, NMWD_LIMIT_ADDR, 32'h00001250);
		host(1'b1, 32'h122FFFFF, 1'b0);
		host(1'b1, 32'h12300000, 1'b1);
		host(1'b1, 32'h12480000, 1'b1);
		host(1'b1, 32'h125FFFFF, 1'b1);
		host(1'b1, 32'h12600000, 1'b0);
		host(1'b0, 32'h12400000, 1'b0);
		// Single 1 MB window, base equal to limit
		apb(1'b1, NMWD_LIMIT_ADDR, 32'h00001230);
		host(1'b1, 32'h123FFFFF, 1'b1);
		host(1'b1, 32'h12400000, 1'b0);
		$display("window decode done");
		// Status: window open, four claims so far, last access unclaimed
		apb(1'b0, NMWD_STATUS_ADDR, 32'h0);
		chk(rd, 32'h00040001);
		apb(1'b1, NMWD_STATUS_ADDR, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h00000000);
		apb(1'b0, NMWD_STATUS_ADDR, 32'h0);
		chk(rd, 32'h00040001);
		$display("status access done");
		// Frozen block holds its last decision while ce is low
		@(posedge pclk);
		go <= 1'b1;
		req_mem <= 1'b1;
		req_addr <= 32'h12300000;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		ce <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk({31'h0, fwd_valid}, 32'h00000001);
		chk({31'h0, fwd_claim}, 32'h00000001);
		@(posedge pclk);
		ce <= 1'b1;
		@(posedge pclk);
		#1;
		chk({31'h0, fwd_valid}, 32'h00000000);
		$display("clock enable done");
		// Lane 0 alone writes field bits 3:0 only; window then inverted
		@(posedge pclk);
		pstrb <= 4'h1;
		apb(1'b1, NMWD_BASE_ADDR, 32'h0000FFF0);
		pstrb <= 4'hF;
		apb(1'b0, NMWD_BASE_ADDR, 32'h0);
		chk(rd, 32'h000012F0);
		host(1'b1, 32'h12F00000, 1'b0);
		$display("byte lanes done");
		// Unmapped word answers with an error
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h00000001);
		chk(rd, 32'h00000000);
		$display("unmapped access done");
		// Reset in mid-run restores the empty window and clears the count
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, NMWD_BASE_ADDR, 32'h0);
		chk(rd, 32'h0000FFF0);
		apb(1'b0, NMWD_LIMIT_ADDR, 32'h0);
		chk(rd, 32'h00000000);
		apb(1'b0, NMWD_STATUS_ADDR, 32'h0);
		chk(rd, 32'h00000000);
		host(1'b1, 32'h12300000, 1'b0);
		$display("mid-run reset done");
		end_of_test();
	end
endmodule : test_nonprefetch_memory_window_decode
